// *** rtl/psc_pkg.sv ***
// Constants for the strap configuration latch
`default_nettype none
package psc_pkg;
  localparam logic [2:0] MODE_RMII_NORMAL_NOX = 3'h1;
  localparam logic [2:0] MODE_B2B_X           = 3'h5;
  localparam logic [2:0] MODE_RMII_NORMAL_X   = 3'h7;
  localparam logic [1:0] ADDR_UPPER_BITS      = 2'h0;
  localparam int         CTRL_ANEG_BIT        = 12;
  localparam logic [15:0] CTRL_RESET_VAL      = 16'h2100;
  localparam logic [4:0] ADDR_RESET_VAL       = 5'h01;
  localparam logic [2:0] MODE_RESET_VAL       = 3'h1;
endpackage : psc_pkg
`default_nettype wire

// *** rtl/psc_strap_latch.sv ***
// Strap capture on reset release and dual-use pin direction control
// What this block does
// - Sample all straps once at reset release
// - Address low three bits from straps, upper 00
// - Decode mode strap 001, 101, 111; others reserved
// - Negotiation strap high disables; loads control bit 12
// - Test-tree strap low enables test-tree mode
// - Filter strap high disables, low enables filtering
// - Interrupt polarity programmable, default low, open-drain
// - Strap pins inputs during reset, outputs after
// - Mode bit one pin has no normal function
`default_nettype none
module psc_strap_latch (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        mgmt_addr_strap_bit0,
  input  wire logic        mgmt_addr_strap_bit1,
  input  wire logic        mgmt_addr_strap_bit2,
  input  wire logic        mode_strap_bit0,
  input  wire logic        mode_strap_bit1,
  input  wire logic        mode_strap_bit2,
  input  wire logic        negotiation_disable_strap,
  input  wire logic        test_tree_disable_strap,
  input  wire logic        emission_filter_disable_strap,
  input  wire logic        irq_active_high,
  input  wire logic        irq_event,
  output logic             strap_pin_oe_n,
  output logic             irq_out,
  output logic             irq_out_oe_n,
  output logic [4:0]       mgmt_addr,
  output logic [2:0]       mode_code,
  output logic             mode_reserved,
  output logic             mode_normal,
  output logic             mode_back_to_back,
  output logic             crossover_en,
  output logic             aneg_enable,
  output logic [15:0]      ctrl_reg0,
  output logic             test_tree_en,
  output logic             emission_filter_en,
  output logic             config_valid
);
  typedef enum logic [0:0] {PSC_IN_RESET, PSC_RUN} psc_state_t;
  psc_state_t state_q;

  // One decode shared by the capture logic and its checks
  function automatic logic psc_mode_known(input logic [2:0] code);
    return (code == psc_pkg::MODE_RMII_NORMAL_NOX) || (code == psc_pkg::MODE_B2B_X)
           || (code == psc_pkg::MODE_RMII_NORMAL_X);
  endfunction : psc_mode_known

  function automatic logic psc_mode_crossover(input logic [2:0] code);
    return (code == psc_pkg::MODE_B2B_X) || (code == psc_pkg::MODE_RMII_NORMAL_X);
  endfunction : psc_mode_crossover

  function automatic logic psc_mode_normal(input logic [2:0] code);
    return (code == psc_pkg::MODE_RMII_NORMAL_NOX) || (code == psc_pkg::MODE_RMII_NORMAL_X);
  endfunction : psc_mode_normal

  // Control word holds one strap bit; refuse a layout it cannot carry
  if (psc_pkg::CTRL_ANEG_BIT < 0 || psc_pkg::CTRL_ANEG_BIT > 15) begin : g_bad_aneg_bit
    $error("negotiation bit outside the control word");
  end
  if (psc_pkg::CTRL_RESET_VAL[psc_pkg::CTRL_ANEG_BIT] != 1'b0) begin : g_bad_ctrl_reset
    $error("control reset value must leave negotiation off");
  end

  // Strap pins stay weak-pulled inputs from reset until the first enabled clock after its release
  wire        capture   = (state_q == PSC_IN_RESET) && !sys_rst;
  wire        take      = capture && clk_en;
  wire [2:0]  mode_w    = {mode_strap_bit2, mode_strap_bit1, mode_strap_bit0};
  wire [4:0]  addr_w    = {psc_pkg::ADDR_UPPER_BITS, mgmt_addr_strap_bit2,
                           mgmt_addr_strap_bit1, mgmt_addr_strap_bit0};
  wire        m_known   = psc_mode_known(mode_w);
  wire        m_b2b     = (mode_w == psc_pkg::MODE_B2B_X);
  wire        m_normal  = psc_mode_normal(mode_w);
  wire        m_xover   = psc_mode_crossover(mode_w);
  wire [15:0] aneg_mask = 16'h0001 << psc_pkg::CTRL_ANEG_BIT;
  // Only the negotiation bit comes from the pin; the rest keeps its default
  wire [15:0] ctrl_w    = negotiation_disable_strap ? (psc_pkg::CTRL_RESET_VAL & ~aneg_mask)
                                                    : (psc_pkg::CTRL_RESET_VAL | aneg_mask);
  wire        irq_lvl   = irq_active_high ? irq_event : !irq_event;
  // Open drain: drive only the low level, pull-up gives the high
  wire        irq_drv   = (state_q == PSC_RUN) && !irq_lvl;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= PSC_IN_RESET;
    end else if (clk_en) begin
      case (state_q)
        PSC_IN_RESET: begin
          if (capture) begin
            state_q <= PSC_RUN;
          end
        end
        PSC_RUN: begin
          state_q <= PSC_RUN;
        end
        default: state_q <= PSC_IN_RESET;
      endcase
    end
  end

  // Straps taken at the release; values frozen afterwards
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_pin_oe_n     <= 1'b1;
      mgmt_addr          <= psc_pkg::ADDR_RESET_VAL;
      mode_code          <= psc_pkg::MODE_RESET_VAL;
      mode_reserved      <= 1'b0;
      mode_normal        <= 1'b1;
      mode_back_to_back  <= 1'b0;
      crossover_en       <= 1'b0;
      aneg_enable        <= 1'b0;
      ctrl_reg0          <= psc_pkg::CTRL_RESET_VAL;
      test_tree_en       <= 1'b0;
      emission_filter_en <= 1'b1;
      config_valid       <= 1'b0;
    end else if (take) begin
      strap_pin_oe_n     <= 1'b0;
      mgmt_addr          <= addr_w;
      mode_code          <= mode_w;
      mode_reserved      <= !m_known;
      mode_normal        <= m_normal;
      mode_back_to_back  <= m_b2b;
      crossover_en       <= m_xover;
      aneg_enable        <= !negotiation_disable_strap;
      ctrl_reg0          <= ctrl_w;
      test_tree_en       <= !test_tree_disable_strap;
      emission_filter_en <= !emission_filter_disable_strap;
      config_valid       <= 1'b1;
    end
  end

  // Irq stays released until the straps are in, so no pin fights a strap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_out      <= 1'b0;
      irq_out_oe_n <= 1'b1;
    end else if (clk_en) begin
      irq_out      <= 1'b0;
      irq_out_oe_n <= !irq_drv;
    end
  end

  // Assertions
  property p_hold;
    @(posedge clk) disable iff (sys_rst)
      (state_q == PSC_RUN) |=> ($stable(mgmt_addr) && $stable(mode_code) && $stable(ctrl_reg0)
                                && $stable(test_tree_en) && $stable(emission_filter_en));
  endproperty
  a_hold: assert property (p_hold) else $error("latched strap changed");
  property p_addr;
    @(posedge clk) disable iff (sys_rst)
      (capture && clk_en) |=> (mgmt_addr == {2'h0, $past(mgmt_addr_strap_bit2),
                                 $past(mgmt_addr_strap_bit1), $past(mgmt_addr_strap_bit0)});
  endproperty
  a_addr: assert property (p_addr) else $error("address capture wrong");
  property p_aneg;
    @(posedge clk) disable iff (sys_rst)
      (capture && clk_en) |=> (ctrl_reg0[12] == !$past(negotiation_disable_strap)) && (aneg_enable == ctrl_reg0[12]);
  endproperty
  a_aneg: assert property (p_aneg) else $error("negotiation bit wrong");
  property p_mode;
    @(posedge clk) disable iff (sys_rst)
      config_valid |-> (crossover_en == psc_mode_crossover(mode_code))
                       && (mode_reserved == !psc_mode_known(mode_code))
                       && (mode_normal == psc_mode_normal(mode_code))
                       && (mode_back_to_back == (mode_code == psc_pkg::MODE_B2B_X));
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_tree;
    @(posedge clk) disable iff (sys_rst)
      (capture && clk_en) |=> (test_tree_en == !$past(test_tree_disable_strap));
  endproperty
  a_tree: assert property (p_tree) else $error("test tree capture wrong");
  property p_filt;
    @(posedge clk) disable iff (sys_rst)
      (capture && clk_en) |=> (emission_filter_en == !$past(emission_filter_disable_strap));
  endproperty
  a_filt: assert property (p_filt) else $error("filter capture wrong");
  property p_dir;
    @(posedge clk) disable iff (sys_rst) !config_valid |-> strap_pin_oe_n;
  endproperty
  a_dir: assert property (p_dir) else $error("pins driven before release");
  property p_once;
    @(posedge clk) disable iff (sys_rst) $rose(config_valid) |-> !strap_pin_oe_n;
  endproperty
  a_once: assert property (p_once) else $error("capture without pin release");
  property p_irq;
    @(posedge clk) disable iff (sys_rst) (irq_out == 1'b0) && (config_valid || irq_out_oe_n);
  endproperty
  a_irq: assert property (p_irq) else $error("irq driven high or before capture");
  property p_cap;
    @(posedge clk) disable iff (sys_rst)
      take |=> config_valid && !strap_pin_oe_n && (mode_code == $past(mode_w));
  endproperty
  a_cap: assert property (p_cap) else $error("straps not taken at release");
  property p_wait;
    @(posedge clk) disable iff (sys_rst)
      (capture && !clk_en) |=> !config_valid && strap_pin_oe_n;
  endproperty
  a_wait: assert property (p_wait) else $error("straps taken while disabled");
  property p_freeze;
    @(posedge clk) disable iff (sys_rst)
      !clk_en |=> $stable(state_q) && $stable(config_valid) && $stable(strap_pin_oe_n)
                  && $stable(irq_out_oe_n) && $stable(mgmt_addr) && $stable(ctrl_reg0);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
  property p_rst;
    @(posedge clk) sys_rst |=> !config_valid && strap_pin_oe_n && irq_out_oe_n
                               && (mgmt_addr == psc_pkg::ADDR_RESET_VAL)
                               && (mode_code == psc_pkg::MODE_RESET_VAL)
                               && (ctrl_reg0 == psc_pkg::CTRL_RESET_VAL);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_irq_pol;
    @(posedge clk) disable iff (sys_rst)
      (config_valid && clk_en) |=> (irq_out_oe_n == ($past(irq_active_high) ? $past(irq_event)
                                                                             : !$past(irq_event)));
  endproperty
  a_irq_pol: assert property (p_irq_pol) else $error("irq polarity wrong");
  c_cap: cover property (@(posedge clk) $rose(config_valid));
  c_b2b: cover property (@(posedge clk) config_valid && mode_back_to_back);
  c_res: cover property (@(posedge clk) config_valid && mode_reserved);
  c_irq: cover property (@(posedge clk) config_valid && !irq_out_oe_n);
  c_wait: cover property (@(posedge clk) capture && !clk_en);
endmodule : psc_strap_latch
`default_nettype wire

// *** verif/psc_strap_board.sv ***
// Board strap pulls and host drivers on the dual-use pins
`default_nettype none
module psc_strap_board (
  input  wire logic       clk,
  input  wire logic       strap_pin_oe_n,
  input  wire logic       drive_en,
  input  wire logic [8:0] pattern,
  output logic      [8:0] straps
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels {filter, tree, aneg, mode, addr} when nobody drives
  localparam logic [8:0] PULLS = 9'h0c1;
  logic [8:0] junk_q;
  // After release the pins are outputs, so show moving junk
  always_ff @(posedge clk) junk_q <= ~straps;
  assign straps = strap_pin_oe_n ? (drive_en ? pattern : PULLS) : junk_q;
endmodule : psc_strap_board
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the strap latch
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, irq_hi = 1'b0, irq_ev = 1'b0, drv = 1'b0, ce = 1'b1;
  logic [8:0] pattern = 9'h000;
  int n_mismatch = 0, tests_run = 0;
  wire logic oe_n, irq_out, irq_oe_n, m_res, m_nrm, m_b2b, xover, aneg, tree, filt, valid;
  wire logic [4:0] addr;
  wire logic [2:0] mode;
  wire logic [15:0] ctrl;
  wire logic [8:0] s;
  always #25 clk = ~clk;
  psc_strap_board psc_strap_board_i (.clk(clk), .strap_pin_oe_n(oe_n), .drive_en(drv), .pattern(pattern), .straps(s));
  psc_strap_latch psc_strap_latch_i (.clk(clk), .sys_rst(sys_rst), .clk_en(ce),
    .mgmt_addr_strap_bit0(s[0]), .mgmt_addr_strap_bit1(s[1]), .mgmt_addr_strap_bit2(s[2]),
    .mode_strap_bit0(s[3]), .mode_strap_bit1(s[4]), .mode_strap_bit2(s[5]), .negotiation_disable_strap(s[6]),
    .test_tree_disable_strap(s[7]), .emission_filter_disable_strap(s[8]), .irq_active_high(irq_hi),
    .irq_event(irq_ev), .strap_pin_oe_n(oe_n), .irq_out(irq_out), .irq_out_oe_n(irq_oe_n), .mgmt_addr(addr),
    .mode_code(mode), .mode_reserved(m_res), .mode_normal(m_nrm), .mode_back_to_back(m_b2b),
    .crossover_en(xover), .aneg_enable(aneg), .ctrl_reg0(ctrl), .test_tree_en(tree),
    .emission_filter_en(filt), .config_valid(valid));
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_cfg(input logic [8:0] p);
    logic [2:0] m;
    m = p[5:3];
    chk("addr", 16'(p[2:0]), 16'(addr));
    chk("mode", 16'(m), 16'(mode));
    chk("flags", 16'({m != 1 && m != 5 && m != 7, m == 1 || m == 7, m == 5, m == 5 || m == 7}),
        16'({m_res, m_nrm, m_b2b, xover}));
    chk("ctrl", psc_pkg::CTRL_RESET_VAL | (16'(!p[6]) << psc_pkg::CTRL_ANEG_BIT), ctrl);
    chk("aneg", 16'(!p[6]), 16'(aneg));
    chk("tree", 16'(!p[7]), 16'(tree));
    chk("filt", 16'(!p[8]), 16'(filt));
    chk("run", 16'h0002, 16'({valid, oe_n}));
  endtask : chk_cfg
  task automatic capture(input logic [8:0] p, input logic d);
    sys_rst = 1'b1;
    drv = d;
    pattern = p;
    tick(2);
    chk("rst", 16'h0003, 16'({oe_n, irq_oe_n}));
    chk("rst_cfg", 16'({psc_pkg::ADDR_RESET_VAL, psc_pkg::MODE_RESET_VAL, 1'b0}), 16'({addr, mode, valid}));
    chk("rst_ctrl", psc_pkg::CTRL_RESET_VAL, ctrl);
    sys_rst = 1'b0;
    tick(1);
    chk_cfg(p);
    tick(3);
    chk_cfg(p);
  endtask : capture
  task automatic stop_test;
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  initial begin
    tick(16);
    capture(9'h0c1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      capture({3'(i), 3'(i), 3'(7 - i)}, 1'b1);
    end
    // Release with the enable low: nothing may be taken until it rises
    sys_rst = 1'b1;
    drv = 1'b1;
    pattern = 9'h0aa;
    irq_ev = 1'b1;
    tick(2);
    ce = 1'b0;
    sys_rst = 1'b0;
    tick(3);
    chk("frozen", 16'h0003, 16'({valid, oe_n, irq_oe_n}));
    ce = 1'b1;
    pattern = 9'h135;
    tick(1);
    chk_cfg(9'h135);
    chk("irq_gate", 16'h0001, 16'(irq_oe_n));
    tick(1);
    chk("irq_low", 16'h0000, 16'(irq_oe_n));
    for (int i = 0; i < 4; i++) begin
      irq_hi = i[1];
      irq_ev = i[0];
      tick(2);
      chk("irq", 16'({1'b0, !(i[0] ^ i[1])}), 16'({irq_out, irq_oe_n}));
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
